// ---- core/cocd_pkg.sv ----
// Constants for the code option decoder: option word layout, register map, encodings
package cocd_pkg;

    // Option word as stored in one-time programmed storage
    localparam int OPT_W          = 12;
    localparam int OPT_SEC_BIT    = 0;     // Read-back protection
    localparam int OPT_LVR_LSB    = 1;     // Three bit threshold index
    localparam int OPT_LVR_W      = 3;
    localparam int OPT_TSRC_BIT   = 4;     // timer_clock_option, 1 = doubled oscillator
    localparam int OPT_TRES_BIT   = 5;     // timer_resolution_option, 1 = 7 bit
    localparam int OPT_EDGE_LSB   = 6;     // Comparator edge, two bits
    localparam int OPT_GATE_BIT   = 8;     // comparator_gates_outputs_option
    localparam int OPT_IRQ0_BIT   = 9;     // irq0_source_option, 1 = port_a_bit5
    localparam int OPT_PAD_BIT    = 10;    // touch_pad_select_option, 1 = touch
    localparam int OPT_EMI_BIT    = 11;    // Clock dither enable

    // Option values in force before the load completes: protected, highest threshold
    localparam logic [OPT_W-1:0] OPT_RST = 12'h0_001;

    // Threshold index 0..7 stands for 4.0, 3.5, 3.0, 2.75, 2.5, 2.2, 2.0, 1.8 volts
    localparam logic [2:0] LVR_4V0  = 3'h0;
    localparam logic [2:0] LVR_1V8  = 3'h7;

    // Comparator edge encodings
    localparam logic [1:0] EDGE_ALL  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    // Timer clock source field value that picks the fast oscillator
    localparam logic [3:0] TSRC_FAST = 4'h2;
    localparam int         TSCL_RES_BIT = 7;

    // Timer clock select outputs
    localparam logic [1:0] TCLK_OTHER = 2'h0;
    localparam logic [1:0] TCLK_FAST  = 2'h1;
    localparam logic [1:0] TCLK_DOUBLE = 2'h2;

    // PWM resolution outputs
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_6 = 2'h1;
    localparam logic [1:0] RES_7 = 2'h2;

    // Register map, byte addresses on the 8 bit plain port
    localparam int            ADDR_W   = 8;
    localparam int            DATA_W   = 8;
    localparam logic [7:0]    REG_OPT_LO = 8'h00;
    localparam logic [7:0]    REG_OPT_HI = 8'h01;
    localparam logic [7:0]    REG_T2CTL  = 8'h02;
    localparam logic [7:0]    REG_T3CTL  = 8'h03;
    localparam logic [7:0]    REG_T2SCL  = 8'h04;
    localparam logic [7:0]    REG_T3SCL  = 8'h05;
    localparam logic [7:0]    REG_INTERRUPT_ENABLE_REG  = 8'h06;
    localparam logic [7:0]    REG_INTERRUPT_REQUEST_REG  = 8'h07;
    localparam logic [7:0]    REG_STAT   = 8'h08;

    // Interrupt bit positions
    localparam int IRQ_PAD0 = 0;
    localparam int IRQ_CMP  = 1;

    // Timing: option load wait and dither step
    localparam int SYNC_STAGES   = 2;
    localparam int LOAD_WAIT     = 4;      // Cycles after reset before the word is taken
    localparam int CLK_MHZ       = 50;
    localparam int DITHER_US     = 1;      // Dither step period in microseconds
    localparam int DITHER_CYC    = DITHER_US * CLK_MHZ;
    localparam logic [7:0] LFSR_SEED = 8'h0_1;

endpackage

// ---- core/cocd_edge_if.sv ----
// Carrier between the decoder top and its edge detectors
`timescale 1ns/1ps
interface cocd_edge_if;
    logic       pin;     // Raw asynchronous pin
    logic [1:0] mode;    // Edge selection
    logic       level;   // Synchronised level
    logic       pulse;   // One cycle event
    modport host (output pin, output mode, input level, input pulse);
    modport det  (input pin, input mode, output level, output pulse);
endinterface

// ---- core/cocd_edge_det.sv ----
// Two flop synchroniser with selectable edge detection
`timescale 1ns/1ps
module cocd_edge_det (
    // Clock and reset
    input  wire logic    sys_clk,
    input  wire logic    reset,
    // Pin and event
    cocd_edge_if.det     eif
);

    logic meta_ff;   // First stage, read only by the second
    logic sync_ff;   // Second stage
    logic prev_ff;   // Last level for edge compare
    logic pulse_ff;  // Registered event

    // Synchroniser stages
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= eif.pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge select, unknown encodings behave as both edges
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pulse_ff <= 1'b0;
        end else begin
            case (eif.mode)
                cocd_pkg::EDGE_RISE: pulse_ff <= sync_ff & ~prev_ff;
                cocd_pkg::EDGE_FALL: pulse_ff <= ~sync_ff & prev_ff;
                default:             pulse_ff <= sync_ff ^ prev_ff;
            endcase
        end
    end

    assign eif.level = sync_ff;
    assign eif.pulse = pulse_ff;

endmodule // cocd_edge_det

// ---- core/cocd_top.sv ----
// Code option decoder: loads fixed options once and steers timers, comparator, pads and clock
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Security blocks program read-back, else allowed
// - Eight level low voltage reset threshold
// - Nibble 0010 picks fast oscillator at 16MHz
// - 32MHz option doubles that timer clock
// - Scale bit 7 gives 6 bit PWM
// - 7 bit option makes it 7 bits
// - Comparator interrupt on both, rising, falling edge
// - Comparator gates all PWM outputs when enabled
// - Interrupt bit 0 from port bit 0 or 5
// - Port bit 7 pad: touch or general I/O
// - EMI option dithers the system clock
module cocd_top #(
    parameter int PWM_N      = 2,                     // Number of PWM outputs
    parameter int DITHER_DIV = cocd_pkg::DITHER_CYC   // Cycles per dither step
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // Programmed option storage
    input  wire logic [cocd_pkg::OPT_W-1:0] otp_word,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // Program read-back
    input  wire logic                  rb_req,
    input  wire logic [15:0]           rb_data_in,
    output logic      [15:0]           rb_data,
    output logic                       rb_valid,
    output logic                       rb_refused,
    // Option steering outputs
    output logic      [2:0]            lvr_level,
    output logic      [3:0]            tmr_clk_sel,       // Two bits per timer
    output logic      [3:0]            tmr_pwm_res,       // Two bits per timer
    output logic      [1:0]            clk_trim,
    output logic                       irq_line,
    // Comparator and interrupt pins
    input  wire logic                  cmp_out,
    input  wire logic                  port_a_bit0,
    input  wire logic                  port_a_bit5,
    // PWM path
    input  wire logic [PWM_N-1:0]      pwm_in,
    output logic      [PWM_N-1:0]      pwm_out,
    // Shared port_a_bit7_touch_pad pad
    input  wire logic                  pad7_in,
    output logic                       pad7_out,
    output logic                       pad7_oe,
    input  wire logic                  gpio7_out,
    input  wire logic                  gpio7_oe,
    output logic                       gpio7_in,
    input  wire logic                  touch_drive,
    output logic                       touch_sense,
    output logic                       touch_sel
);

    // Option storage path
    logic [cocd_pkg::OPT_W-1:0] otp_meta_ff;     // First sync stage
    logic [cocd_pkg::OPT_W-1:0] otp_sync_ff;     // Second sync stage
    logic [cocd_pkg::OPT_W-1:0] opt_ff;          // Option word in force
    logic                       loaded_ff;       // Set once the word is taken
    logic [2:0]                 load_cnt_ff;     // Wait after reset release

    // Registers software owns
    logic [7:0] tctl_ff [2];                     // timer_two_control, timer_three_control
    logic [7:0] tscl_ff [2];                     // timer_two_scale, timer_three_scale
    logic [7:0] interrupt_enable_reg_ff;                        // interrupt_enable_reg
    logic [7:0] interrupt_request_reg_ff;                        // interrupt_request_reg

    // Output flops
    logic [7:0]       rdata_ff;
    logic [15:0]      rb_data_ff;
    logic             rb_valid_ff;
    logic             rb_refused_ff;
    logic [3:0]       clk_sel_ff;
    logic [3:0]       res_ff;
    logic [1:0]       trim_ff;
    logic             irq_ff;
    logic [PWM_N-1:0] pwm_ff;
    logic             pad_out_ff;
    logic             pad_oe_ff;
    logic             gpio_in_ff;
    logic             touch_in_ff;
    logic             pad_meta_ff;               // Pad input sync stage one
    logic             pad_sync_ff;               // Pad input sync stage two

    // Dither generator
    logic [15:0] div_cnt_ff;                     // Divider toward the step enable
    logic        step_en_ff;                     // One cycle dither step
    logic [7:0]  lfsr_ff;                        // Pseudo random pattern

    // Decoded option fields
    logic       opt_sec;
    logic [2:0] opt_lvr;
    logic       opt_tdbl;
    logic       opt_t7;
    logic [1:0] opt_edge;
    logic       opt_gate;
    logic       opt_irq0_b5;
    logic       opt_touch;
    logic       opt_emi;

    assign opt_sec     = opt_ff[cocd_pkg::OPT_SEC_BIT];
    assign opt_lvr     = opt_ff[cocd_pkg::OPT_LVR_LSB +: cocd_pkg::OPT_LVR_W];
    assign opt_tdbl    = opt_ff[cocd_pkg::OPT_TSRC_BIT];
    assign opt_t7      = opt_ff[cocd_pkg::OPT_TRES_BIT];
    assign opt_edge    = opt_ff[cocd_pkg::OPT_EDGE_LSB +: 2];
    assign opt_gate    = opt_ff[cocd_pkg::OPT_GATE_BIT];
    assign opt_irq0_b5 = opt_ff[cocd_pkg::OPT_IRQ0_BIT];
    assign opt_touch   = opt_ff[cocd_pkg::OPT_PAD_BIT];
    assign opt_emi     = opt_ff[cocd_pkg::OPT_EMI_BIT];

    // Edge detectors for comparator and interrupt source 0
    cocd_edge_if cmp_if ();
    cocd_edge_if irq0_if ();

    assign cmp_if.pin   = cmp_out;
    assign cmp_if.mode  = opt_edge;
    assign irq0_if.pin  = opt_irq0_b5 ? port_a_bit5 : port_a_bit0;
    assign irq0_if.mode = cocd_pkg::EDGE_RISE;

    cocd_edge_det u_cmp_det (
        .sys_clk (sys_clk),
        .reset   (reset),
        .eif     (cmp_if)
    );

    cocd_edge_det u_irq0_det (
        .sys_clk (sys_clk),
        .reset   (reset),
        .eif     (irq0_if)
    );

    // Storage word is static but foreign to this clock, so it is synchronised
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            otp_meta_ff <= '0;
            otp_sync_ff <= '0;
        end else begin
            otp_meta_ff <= otp_word;
            otp_sync_ff <= otp_meta_ff;
        end
    end

    // Take the word once after reset; later the loaded flag freezes it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            opt_ff      <= cocd_pkg::OPT_RST;
            loaded_ff   <= 1'b0;
            load_cnt_ff <= 3'h0;
        end else if (!loaded_ff) begin
            if (load_cnt_ff == 3'(cocd_pkg::LOAD_WAIT)) begin
                opt_ff    <= otp_sync_ff;
                loaded_ff <= 1'b1;
            end else begin
                load_cnt_ff <= load_cnt_ff + 3'h1;
            end
        end
    end

    // Timer control and scale registers, one pair per timer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tctl_ff[0] <= 8'h0_0;
            tctl_ff[1] <= 8'h0_0;
            tscl_ff[0] <= 8'h0_0;
            tscl_ff[1] <= 8'h0_0;
        end else if (reg_wr) begin
            case (reg_addr)
                cocd_pkg::REG_T2CTL: tctl_ff[0] <= reg_wdata;
                cocd_pkg::REG_T3CTL: tctl_ff[1] <= reg_wdata;
                cocd_pkg::REG_T2SCL: tscl_ff[0] <= reg_wdata;
                cocd_pkg::REG_T3SCL: tscl_ff[1] <= reg_wdata;
                default: ;                                 // Option registers ignore writes
            endcase
        end
    end

    // Interrupt enable register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            interrupt_enable_reg_ff <= 8'h0_0;
        end else if (reg_wr && reg_addr == cocd_pkg::REG_INTERRUPT_ENABLE_REG) begin
            interrupt_enable_reg_ff <= reg_wdata;
        end
    end

    // Request bits: software write stores, hardware events set; a set wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            interrupt_request_reg_ff <= 8'h0_0;
        end else begin
            interrupt_request_reg_ff <= ((reg_wr && reg_addr == cocd_pkg::REG_INTERRUPT_REQUEST_REG) ? reg_wdata : interrupt_request_reg_ff)
                      | (8'(irq0_if.pulse) << cocd_pkg::IRQ_PAD0)
                      | (8'(cmp_if.pulse) << cocd_pkg::IRQ_CMP);
        end
    end

    // Combined request line to the core
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(interrupt_request_reg_ff & interrupt_enable_reg_ff);
        end
    end

    // Register read, data stand one cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (reset || !reg_rd) begin
            rdata_ff <= 8'h0_0;
        end else begin
            case (reg_addr)
                cocd_pkg::REG_OPT_LO: rdata_ff <= opt_ff[7:0];
                cocd_pkg::REG_OPT_HI: rdata_ff <= {4'h0, opt_ff[11:8]};
                cocd_pkg::REG_T2CTL:  rdata_ff <= tctl_ff[0];
                cocd_pkg::REG_T3CTL:  rdata_ff <= tctl_ff[1];
                cocd_pkg::REG_T2SCL:  rdata_ff <= tscl_ff[0];
                cocd_pkg::REG_T3SCL:  rdata_ff <= tscl_ff[1];
                cocd_pkg::REG_INTERRUPT_ENABLE_REG:  rdata_ff <= interrupt_enable_reg_ff;
                cocd_pkg::REG_INTERRUPT_REQUEST_REG:  rdata_ff <= interrupt_request_reg_ff;
                cocd_pkg::REG_STAT:   rdata_ff <= {5'h0_0, cmp_if.level, opt_sec, loaded_ff};
                default:              rdata_ff <= 8'h0_0;      // Unmapped reads zero
            endcase
        end
    end

    // Program read-back gate; refused until options are known as well
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rb_data_ff    <= 16'h0_000;
            rb_valid_ff   <= 1'b0;
            rb_refused_ff <= 1'b0;
        end else begin
            rb_valid_ff   <= rb_req && loaded_ff && !opt_sec;
            rb_refused_ff <= rb_req && (opt_sec || !loaded_ff);
            rb_data_ff    <= (rb_req && loaded_ff && !opt_sec) ? rb_data_in : 16'h0_000;
        end
    end

    // Per timer clock source and PWM resolution decode
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                clk_sel_ff[2*t +: 2] <= cocd_pkg::TCLK_OTHER;
                res_ff[2*t +: 2]     <= cocd_pkg::RES_8;
            end else begin
                if (tctl_ff[t][7:4] == cocd_pkg::TSRC_FAST) begin
                    clk_sel_ff[2*t +: 2] <= opt_tdbl ? cocd_pkg::TCLK_DOUBLE
                                                     : cocd_pkg::TCLK_FAST;
                end else begin
                    clk_sel_ff[2*t +: 2] <= cocd_pkg::TCLK_OTHER;
                end
                if (tscl_ff[t][cocd_pkg::TSCL_RES_BIT]) begin
                    res_ff[2*t +: 2] <= opt_t7 ? cocd_pkg::RES_7
                                               : cocd_pkg::RES_6;
                end else begin
                    res_ff[2*t +: 2] <= cocd_pkg::RES_8;
                end
            end
        end
    end

    // PWM gating: comparator low forces every output low when enabled
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwm_ff <= '0;
        end else if (opt_gate) begin
            pwm_ff <= pwm_in & {PWM_N{cmp_if.level}};
        end else begin
            pwm_ff <= pwm_in;
        end
    end

    // Pad input synchroniser
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_meta_ff <= 1'b0;
            pad_sync_ff <= 1'b0;
        end else begin
            pad_meta_ff <= pad7_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // Shared pad steering between touch sensing and general I/O
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_out_ff  <= 1'b0;
            pad_oe_ff   <= 1'b0;
            gpio_in_ff  <= 1'b0;
            touch_in_ff <= 1'b0;
        end else if (opt_touch) begin
            pad_out_ff  <= touch_drive;
            pad_oe_ff   <= 1'b1;
            gpio_in_ff  <= 1'b0;
            touch_in_ff <= pad_sync_ff;
        end else begin
            pad_out_ff  <= gpio7_out;
            pad_oe_ff   <= gpio7_oe;
            gpio_in_ff  <= pad_sync_ff;
            touch_in_ff <= 1'b0;
        end
    end

    // Divider giving the dither step enable
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_cnt_ff <= 16'h0_000;
            step_en_ff <= 1'b0;
        end else if (div_cnt_ff == 16'(DITHER_DIV - 1)) begin
            div_cnt_ff <= 16'h0_000;
            step_en_ff <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0_001;
            step_en_ff <= 1'b0;
        end
    end

    // Pattern for the oscillator trim; zero trim means no dither
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lfsr_ff <= cocd_pkg::LFSR_SEED;
            trim_ff <= 2'h0;
        end else if (!opt_emi) begin
            trim_ff <= 2'h0;
        end else if (step_en_ff) begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            trim_ff <= lfsr_ff[1:0];
        end
    end

    // Threshold is held in the option flop itself
    assign lvr_level   = opt_lvr;
    assign reg_rdata   = rdata_ff;
    assign rb_data     = rb_data_ff;
    assign rb_valid    = rb_valid_ff;
    assign rb_refused  = rb_refused_ff;
    assign tmr_clk_sel = clk_sel_ff;
    assign tmr_pwm_res = res_ff;
    assign clk_trim    = trim_ff;
    assign irq_line    = irq_ff;
    assign pwm_out     = pwm_ff;
    assign pad7_out    = pad_out_ff;
    assign pad7_oe     = pad_oe_ff;
    assign gpio7_in    = gpio_in_ff;
    assign touch_sense = touch_in_ff;
    assign touch_sel   = opt_touch;

endmodule // cocd_top

// ---- bench/cocd_monitor.sv ----
// Port-level checker for the code option decoder
`timescale 1ns/1ps
module cocd_monitor #(
    parameter int PWM_N = 2                // Number of PWM outputs
) (
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             reset,
    // Register read path
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    // Program read-back
    input wire logic             rb_req,
    input wire logic [15:0]      rb_data_in,
    input wire logic [15:0]      rb_data,
    input wire logic             rb_valid,
    input wire logic             rb_refused,
    // Option steering
    input wire logic [2:0]       lvr_level,
    input wire logic [3:0]       tmr_clk_sel,
    input wire logic             touch_sel,
    // PWM path
    input wire logic [PWM_N-1:0] pwm_in,
    input wire logic [PWM_N-1:0] pwm_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Cycles since reset release; saturates so the load has surely landed
    logic [3:0] settle_ff;

    // Settle counter, restarted by every reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            settle_ff <= 4'h0;
        end else if (settle_ff != 4'hF) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end

    rb_answer_a: assert property (rb_req |=> rb_valid || rb_refused) else $error("read-back unanswered");
    rb_excl_a: assert property (!(rb_valid && rb_refused)) else $error("read-back both granted and refused");
    rb_data_a: assert property (rb_valid |-> rb_data == $past(rb_data_in)) else $error("read-back word wrong");
    refused_zero_a: assert property (rb_refused |-> rb_data == 16'h0_000) else $error("refused read leaks");
    rb_unasked_a: assert property (!$past(rb_req) |-> !rb_valid && !rb_refused) else $error("answer unasked");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    clk_sel_legal_a: assert property (tmr_clk_sel[1:0] != 2'h3 && tmr_clk_sel[3:2] != 2'h3)
        else $error("timer clock select code unused");
    option_hold_a: assert property (settle_ff == 4'hF |-> $stable(lvr_level) && $stable(touch_sel))
        else $error("option moved after load");
    pwm_gate_a: assert property ((pwm_out & ~$past(pwm_in)) == '0) else $error("PWM output without input");
endmodule // cocd_monitor

bind cocd_top cocd_monitor #(.PWM_N(PWM_N)) cocd_monitor_inst (.sys_clk, .reset, .reg_rd, .reg_rdata, .rb_req,
    .rb_data_in, .rb_data, .rb_valid, .rb_refused, .lvr_level, .tmr_clk_sel, .touch_sel, .pwm_in, .pwm_out);

// ---- bench/test_cocd_top.sv ----
// Self-checking bench for the code option decoder
`timescale 1ns/1ps
module test_cocd_top;
    // Design inputs, all given a value at time zero
    logic        sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rb_req = 1'b0;
    logic [11:0] otp_word = 12'h0_000;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [15:0] rb_data_in = 16'h0_000;
    logic        cmp_out = 1'b0, port_a_bit0 = 1'b0, port_a_bit5 = 1'b0;
    logic [1:0]  pwm_in = 2'h0;
    logic        pad7_in = 1'b0, gpio7_out = 1'b0, gpio7_oe = 1'b0, touch_drive = 1'b0;
    // Design outputs
    logic [7:0]  reg_rdata;
    logic [15:0] rb_data;
    logic        rb_valid, rb_refused, irq_line, pad7_out, pad7_oe, gpio7_in, touch_sense, touch_sel;
    logic [2:0]  lvr_level;
    logic [3:0]  tmr_clk_sel, tmr_pwm_res;
    logic [1:0]  clk_trim, pwm_out, last_trim, edge_sel;
    // Bench state; four option words cover every edge mode and both ways of each switch
    int          miscompares = 0, checked = 0, hops;
    logic [7:0]  rv;
    logic [11:0] o;
    logic        sec, tsrc, tres, gate, src5, pad, emi;
    logic [11:0] cfg [4] = '{12'hF4E, 12'h1B7, 12'h2D0, 12'h801};

    // Small dither divider keeps the dither test short
    cocd_top #(.PWM_N(2), .DITHER_DIV(4)) cocd_top_inst (.sys_clk, .reset, .otp_word, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .rb_req, .rb_data_in, .rb_data, .rb_valid, .rb_refused, .lvr_level,
        .tmr_clk_sel, .tmr_pwm_res, .clk_trim, .irq_line, .cmp_out, .port_a_bit0, .port_a_bit5, .pwm_in,
        .pwm_out, .pad7_in, .pad7_out, .pad7_oe, .gpio7_out, .gpio7_oe, .gpio7_in, .touch_drive,
        .touch_sense, .touch_sel);

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    // Verdict and end of run
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One comparison, counted
    task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // One cycle read strobe; data are taken in the single cycle after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Read and compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        check(nm, d, exp);
    endtask

    // Let a pin change cross the synchroniser and the edge logic
    task automatic settle();
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    // Reset with a new option word and wait, bounded, for the load flag
    task automatic start(input logic [11:0] w);
        @(posedge sys_clk);
        reset <= 1'b1;
        otp_word <= w;
        {cmp_out, port_a_bit0, port_a_bit5, touch_drive, pad7_in, pwm_in} <= '0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rv = 8'h00;
        for (int i = 0; i < 20 && rv[0] !== 1'b1; i++) rd(cocd_pkg::REG_STAT, rv);
        if (rv[0] !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask

    // Main sequence: one pass per programmed option word
    initial begin
        for (int c = 0; c < 4; c++) begin
            o = cfg[c];
            {sec, tsrc, tres} = {o[cocd_pkg::OPT_SEC_BIT], o[cocd_pkg::OPT_TSRC_BIT], o[cocd_pkg::OPT_TRES_BIT]};
            {gate, src5, pad} = {o[cocd_pkg::OPT_GATE_BIT], o[cocd_pkg::OPT_IRQ0_BIT], o[cocd_pkg::OPT_PAD_BIT]};
            emi = o[cocd_pkg::OPT_EMI_BIT];
            edge_sel = o[cocd_pkg::OPT_EDGE_LSB +: 2];
            start(o);
            check("lvr_level", lvr_level, o[cocd_pkg::OPT_LVR_LSB +: cocd_pkg::OPT_LVR_W]);
            // Option bytes are read-only: a write must leave them alone
            wr(cocd_pkg::REG_OPT_LO, ~o[7:0]);
            rdc(cocd_pkg::REG_OPT_LO, o[7:0], "option low");
            rdc(cocd_pkg::REG_OPT_HI, {4'h0, o[11:8]}, "option high");
            // Timer two picks the fast oscillator, timer three another source
            wr(cocd_pkg::REG_T2CTL, 8'h20);
            wr(cocd_pkg::REG_T3CTL, 8'h10);
            wr(cocd_pkg::REG_T2SCL, 8'h80);
            wr(cocd_pkg::REG_T3SCL, 8'h00);
            settle();
            check("tmr_clk_sel", tmr_clk_sel,
                  {cocd_pkg::TCLK_OTHER, tsrc ? cocd_pkg::TCLK_DOUBLE : cocd_pkg::TCLK_FAST});
            check("tmr_pwm_res", tmr_pwm_res, {cocd_pkg::RES_8, tres ? cocd_pkg::RES_7 : cocd_pkg::RES_6});
            // Program read-back request
            @(posedge sys_clk);
            rb_req <= 1'b1;
            rb_data_in <= 16'hA5C3;
            @(posedge sys_clk);
            rb_req <= 1'b0;
            #1;
            check("read-back", {rb_valid, rb_refused, rb_data}, {!sec, sec, sec ? 16'h0_000 : 16'hA5C3});
            // PWM with comparator low, then high while its rising edge is caught
            pwm_in <= 2'h3;
            settle();
            check("pwm_out low cmp", pwm_out, gate ? 2'h0 : 2'h3);
            wr(cocd_pkg::REG_INTERRUPT_ENABLE_REG, 8'h03);
            wr(cocd_pkg::REG_INTERRUPT_REQUEST_REG, 8'h00);
            cmp_out <= 1'b1;
            settle();
            check("pwm_out high cmp", pwm_out, 2'h3);
            check("irq_line", irq_line, edge_sel != cocd_pkg::EDGE_FALL);
            rdc(cocd_pkg::REG_INTERRUPT_REQUEST_REG, {6'h0, edge_sel != cocd_pkg::EDGE_FALL, 1'b0}, "rise event");
            wr(cocd_pkg::REG_INTERRUPT_REQUEST_REG, 8'h00);
            cmp_out <= 1'b0;
            settle();
            rdc(cocd_pkg::REG_INTERRUPT_REQUEST_REG, {6'h0, edge_sel != cocd_pkg::EDGE_RISE, 1'b0}, "fall event");
            // Interrupt source 0 from either port bit
            wr(cocd_pkg::REG_INTERRUPT_REQUEST_REG, 8'h00);
            port_a_bit5 <= 1'b1;
            settle();
            rdc(cocd_pkg::REG_INTERRUPT_REQUEST_REG, {7'h0, src5}, "irq0 bit5");
            wr(cocd_pkg::REG_INTERRUPT_REQUEST_REG, 8'h00);
            port_a_bit0 <= 1'b1;
            settle();
            rdc(cocd_pkg::REG_INTERRUPT_REQUEST_REG, {7'h0, !src5}, "irq0 bit0");
            // Shared pad: touch drive reaches the pin only in touch mode
            touch_drive <= 1'b1;
            settle();
            check("pad select", {touch_sel, pad7_oe, pad7_out}, {3{pad}});
            // Pad level reaches only the side that owns the pad
            pad7_in <= 1'b1;
            settle();
            check("pad input", {gpio7_in, touch_sense}, {!pad, pad});
            // Clock dither must move the trim only when enabled
            last_trim = clk_trim;
            hops = 0;
            repeat (40) begin
                @(posedge sys_clk);
                #1;
                if (clk_trim !== last_trim) hops++;
                last_trim = clk_trim;
            end
            check("dither", hops != 0, emi);
        end
        close_out();
    end
endmodule // test_cocd_top
